// >>> common/pfs_pkg.sv
// Constants, types and decode helpers of the port function select block
package pfs_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [15:0] PFS_P4H_INDEX = 16'h52a9;
    localparam logic [15:0] PFS_P5L_INDEX = 16'h52aa;
    localparam logic [15:0] PFS_P5H_INDEX = 16'h52ab;
    localparam int PFS_ADDR_WIDTH = 18;

    // Field positions
    localparam int PFS_TCLK_LSB = 2;
    localparam int PFS_REMOTE_OUTPUT_LSB = 0;
    localparam int PFS_P53_LSB = 6;
    localparam int PFS_P52_LSB = 4;
    localparam int PFS_P51_LSB = 2;
    localparam int PFS_P50_LSB = 0;
    localparam int PFS_P55_LSB = 2;
    localparam int PFS_P54_LSB = 0;

    // Function codes and reset values
    localparam logic [1:0] PFS_SEL_PORT = 2'h0;
    localparam logic [1:0] PFS_SEL_ALT1 = 2'h1;
    localparam logic [1:0] PFS_SEL_ALT2 = 2'h2;
    localparam logic [1:0] PFS_FIELD_RESET = 2'h0;
    localparam logic [3:0] PFS_HALF_RESET = 4'h0;
    localparam logic [7:0] PFS_FULL_RESET = 8'h00;
    localparam logic [3:0] PFS_UNUSED_READ = 4'h0;
    localparam logic [31:0] PFS_RDATA_RESET = 32'h0000_0000;

    // Pin order on the pad vectors
    localparam int PFS_NUM_PINS = 8;
    localparam int PFS_PIN_REMOTE_OUTPUT = 0;
    localparam int PFS_PIN_TCLK = 1;
    localparam int PFS_PIN_P50 = 2;
    localparam int PFS_PIN_P51 = 3;
    localparam int PFS_PIN_P52 = 4;
    localparam int PFS_PIN_P53 = 5;
    localparam int PFS_PIN_P54 = 6;
    localparam int PFS_PIN_P55 = 7;

    // Level seen by a peripheral input whose pin is not routed to it
    localparam logic PFS_TWOWIRE_IDLE = 1'b1;
    localparam logic PFS_SERIAL_IDLE = 1'b0;

    typedef enum logic [0:0] {
        PFS_BUS_IDLE = 1'b0,
        PFS_BUS_DONE = 1'b1
    } pfs_bus_state_type;

    function automatic logic [PFS_ADDR_WIDTH-1:0] pfs_byte_addr(
        input logic [15:0] idx
    );
        return {idx, 2'b00};
    endfunction

    function automatic logic pfs_is_alt1(input logic [1:0] sel);
        return sel == PFS_SEL_ALT1;
    endfunction

    function automatic logic pfs_is_alt2(input logic [1:0] sel);
        return sel == PFS_SEL_ALT2;
    endfunction

endpackage

// >>> verilog/pfs_pin_route.sv
// One pad: choose between general port and peripheral drive, register all
`timescale 1ns/1ps
module pfs_pin_route
    import pfs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_route_alt,
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    input wire logic i_alt_out,
    input wire logic i_alt_oe,
    input wire logic i_pad_in,
    output logic o_pad_out,
    output logic o_pad_oe,
    output logic o_gpio_in
);

    logic next_pad_out;
    logic next_pad_oe;

    always_comb begin
        if (i_route_alt) begin
            next_pad_out = i_alt_out;
            next_pad_oe = i_alt_oe;
        end else begin
            next_pad_out = i_gpio_out;
            next_pad_oe = i_gpio_oe;
        end
    end

    // Port input always reflects the pad, whatever owns the driver
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pad_out <= 1'b0;
            o_pad_oe <= 1'b0;
            o_gpio_in <= 1'b0;
        end else begin
            o_pad_out <= next_pad_out;
            o_pad_oe <= next_pad_oe;
            o_gpio_in <= i_pad_in;
        end
    end

endmodule // pfs_pin_route

// >>> verilog/pfs_top.sv
// Function select registers and pin routing for P44, P45 and P50 to P55
`timescale 1ns/1ps

module pfs_top
    import pfs_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
)
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [PFS_ADDR_WIDTH-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic [PFS_NUM_PINS-1:0] I_PAD_IN,
    output logic [PFS_NUM_PINS-1:0] O_PAD_OUT,
    output logic [PFS_NUM_PINS-1:0] O_PAD_OE,
    input wire logic [PFS_NUM_PINS-1:0] I_GPIO_OUT,
    input wire logic [PFS_NUM_PINS-1:0] I_GPIO_OE,
    output logic [PFS_NUM_PINS-1:0] O_GPIO_IN,
    input wire logic I_MASTER_TWOWIRE_DATA_OUT,
    input wire logic I_MASTER_TWOWIRE_DATA_OE,
    output logic O_MASTER_TWOWIRE_DATA_IN,
    input wire logic I_SLAVE_TWOWIRE_CLOCK_OUT,
    input wire logic I_SLAVE_TWOWIRE_CLOCK_OE,
    output logic O_SLAVE_TWOWIRE_CLOCK_IN,
    input wire logic I_REMOTE_OUTPUT,
    output logic O_TIMER_EXTERNAL_CLOCK_IN,
    output logic O_SERIAL_CH0_DATA_IN,
    input wire logic I_SERIAL_CH0_DATA_OUT,
    input wire logic I_SERIAL_CH0_CLOCK_OUT,
    input wire logic I_SERIAL_CH0_CLOCK_OE,
    output logic O_SERIAL_CH0_CLOCK_IN,
    output logic O_SERIAL_CH1_DATA_IN,
    input wire logic I_SERIAL_CH1_DATA_OUT,
    input wire logic I_SERIAL_CH1_CLOCK_OUT,
    input wire logic I_SERIAL_CH1_CLOCK_OE,
    output logic O_SERIAL_CH1_CLOCK_IN
);

    pfs_bus_state_type state;
    pfs_bus_state_type next_state;
    logic next_waitrequest;
    logic [31:0] next_readdata;
    logic write_commit;

    logic [3:0] port4_high_function_select;
    logic [7:0] port5_low_function_select;
    logic [3:0] port5_high_function_select;
    logic [3:0] next_port4_high;
    logic [7:0] next_port5_low;
    logic [3:0] next_port5_high;

    logic [1:0] timer_clock_pin_select;
    logic [1:0] remote_out_pin_select;
    logic [1:0] port5_pin0_select;
    logic [1:0] port5_pin1_select;
    logic [1:0] port5_pin2_select;
    logic [1:0] port5_pin3_select;
    logic [1:0] port5_pin4_select;
    logic [1:0] port5_pin5_select;

    logic [PFS_NUM_PINS-1:0] route_alt;
    logic [PFS_NUM_PINS-1:0] alt_out;
    logic [PFS_NUM_PINS-1:0] alt_oe;

    logic next_twm_data_in;
    logic next_tws_clock_in;
    logic next_timer_clock_in;
    logic next_ser0_data_in;
    logic next_ser0_clock_in;
    logic next_ser1_data_in;
    logic next_ser1_clock_in;

    // One-hot register hit: bit 0 port four, 1 port five low, 2 high
    function automatic logic [2:0] reg_hit(
        input logic [PFS_ADDR_WIDTH-1:0] addr
    );
        logic [2:0] hit;
        hit = 3'h0;
        if (addr == pfs_byte_addr(PFS_P4H_INDEX)) begin
            hit = 3'h1;
        end else if (addr == pfs_byte_addr(PFS_P5L_INDEX)) begin
            hit = LARGE_PACKAGE ? 3'h2 : 3'h0;
        end else if (addr == pfs_byte_addr(PFS_P5H_INDEX)) begin
            hit = LARGE_PACKAGE ? 3'h4 : 3'h0;
        end
        return hit;
    endfunction

    // Field extraction from the stored select bits
    assign timer_clock_pin_select =
        port4_high_function_select[PFS_TCLK_LSB +: 2];
    assign remote_out_pin_select =
        port4_high_function_select[PFS_REMOTE_OUTPUT_LSB +: 2];
    assign port5_pin3_select = port5_low_function_select[PFS_P53_LSB+:2];
    assign port5_pin2_select = port5_low_function_select[PFS_P52_LSB+:2];
    assign port5_pin1_select = port5_low_function_select[PFS_P51_LSB+:2];
    assign port5_pin0_select = port5_low_function_select[PFS_P50_LSB+:2];
    assign port5_pin5_select =
        port5_high_function_select[PFS_P55_LSB +: 2];
    assign port5_pin4_select =
        port5_high_function_select[PFS_P54_LSB +: 2];

    // Bus: answer one cycle after the request, commit at the release edge
    always_comb begin
        next_state = state;
        next_waitrequest = O_AVS_WAITREQUEST;
        next_readdata = O_AVS_READDATA;
        write_commit = 1'b0;
        case (state)
            PFS_BUS_IDLE: begin
                if (I_AVS_READ || I_AVS_WRITE) begin
                    next_state = PFS_BUS_DONE;
                    next_waitrequest = 1'b0;
                    next_readdata = PFS_RDATA_RESET;
                    if (I_AVS_READ) begin
                        if (reg_hit(I_AVS_ADDRESS) == 3'h1) begin
                            next_readdata[7:0] = {PFS_UNUSED_READ,
                                port4_high_function_select};
                        end else if (reg_hit(I_AVS_ADDRESS) == 3'h2) begin
                            next_readdata[7:0] = port5_low_function_select;
                        end else if (reg_hit(I_AVS_ADDRESS) == 3'h4) begin
                            next_readdata[7:0] = {PFS_UNUSED_READ,
                                port5_high_function_select};
                        end
                    end
                end
            end
            PFS_BUS_DONE: begin
                next_state = PFS_BUS_IDLE;
                next_waitrequest = 1'b1;
                write_commit = I_AVS_WRITE;
            end
            default: begin
                next_state = PFS_BUS_IDLE;
                next_waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state <= PFS_BUS_IDLE;
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= PFS_RDATA_RESET;
        end else begin
            state <= next_state;
            O_AVS_WAITREQUEST <= next_waitrequest;
            O_AVS_READDATA <= next_readdata;
        end
    end

    // Select registers; only the low byte lane carries them
    always_comb begin
        next_port4_high = port4_high_function_select;
        next_port5_low = port5_low_function_select;
        next_port5_high = port5_high_function_select;
        if (write_commit && I_AVS_BYTEENABLE[0]) begin
            if (reg_hit(I_AVS_ADDRESS) == 3'h1) begin
                next_port4_high = I_AVS_WRITEDATA[3:0];
            end else if (reg_hit(I_AVS_ADDRESS) == 3'h2) begin
                next_port5_low = I_AVS_WRITEDATA[7:0];
            end else if (reg_hit(I_AVS_ADDRESS) == 3'h4) begin
                next_port5_high = I_AVS_WRITEDATA[3:0];
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            port4_high_function_select <= PFS_HALF_RESET;
            port5_low_function_select <= PFS_FULL_RESET;
            port5_high_function_select <= PFS_HALF_RESET;
        end else begin
            port4_high_function_select <= next_port4_high;
            port5_low_function_select <= next_port5_low;
            port5_high_function_select <= next_port5_high;
        end
    end

    // Per-pin peripheral drive; reserved codes fall back to the port
    always_comb begin
        route_alt = '0;
        alt_out = '0;
        alt_oe = '0;
        if (pfs_is_alt2(remote_out_pin_select)) begin
            route_alt[PFS_PIN_REMOTE_OUTPUT] = 1'b1;
            alt_out[PFS_PIN_REMOTE_OUTPUT] = I_REMOTE_OUTPUT;
            alt_oe[PFS_PIN_REMOTE_OUTPUT] = 1'b1;
        end else if (pfs_is_alt1(remote_out_pin_select)) begin
            route_alt[PFS_PIN_REMOTE_OUTPUT] = 1'b1;
            alt_out[PFS_PIN_REMOTE_OUTPUT] = I_SLAVE_TWOWIRE_CLOCK_OUT;
            alt_oe[PFS_PIN_REMOTE_OUTPUT] = I_SLAVE_TWOWIRE_CLOCK_OE;
        end
        if (pfs_is_alt1(timer_clock_pin_select)) begin
            route_alt[PFS_PIN_TCLK] = 1'b1;
            alt_out[PFS_PIN_TCLK] = I_MASTER_TWOWIRE_DATA_OUT;
            alt_oe[PFS_PIN_TCLK] = I_MASTER_TWOWIRE_DATA_OE;
        end
        if (LARGE_PACKAGE) begin
            route_alt[PFS_PIN_P50] = pfs_is_alt1(port5_pin0_select);
            route_alt[PFS_PIN_P51] = pfs_is_alt1(port5_pin1_select);
            route_alt[PFS_PIN_P52] = pfs_is_alt1(port5_pin2_select);
            route_alt[PFS_PIN_P53] = pfs_is_alt1(port5_pin3_select);
            route_alt[PFS_PIN_P54] = pfs_is_alt1(port5_pin4_select);
            route_alt[PFS_PIN_P55] = pfs_is_alt1(port5_pin5_select);
        end
        // Data inputs leave the driver off
        alt_out[PFS_PIN_P51] = I_SERIAL_CH0_DATA_OUT;
        alt_oe[PFS_PIN_P51] = 1'b1;
        alt_out[PFS_PIN_P52] = I_SERIAL_CH0_CLOCK_OUT;
        alt_oe[PFS_PIN_P52] = I_SERIAL_CH0_CLOCK_OE;
        alt_out[PFS_PIN_P54] = I_SERIAL_CH1_DATA_OUT;
        alt_oe[PFS_PIN_P54] = 1'b1;
        alt_out[PFS_PIN_P55] = I_SERIAL_CH1_CLOCK_OUT;
        alt_oe[PFS_PIN_P55] = I_SERIAL_CH1_CLOCK_OE;
    end

    genvar pin;
    generate
        for (pin = 0; pin < PFS_NUM_PINS; pin++) begin : g_pin
            pfs_pin_route u_route (
                .i_clk(I_CLK),
                .i_rst(I_RST),
                .i_route_alt(route_alt[pin]),
                .i_gpio_out(I_GPIO_OUT[pin]),
                .i_gpio_oe(I_GPIO_OE[pin]),
                .i_alt_out(alt_out[pin]),
                .i_alt_oe(alt_oe[pin]),
                .i_pad_in(I_PAD_IN[pin]),
                .o_pad_out(O_PAD_OUT[pin]),
                .o_pad_oe(O_PAD_OE[pin]),
                .o_gpio_in(O_GPIO_IN[pin])
            );
        end
    endgenerate

    // Peripheral inputs see the pad only while their pin is routed to them; the timer clock only while its pin holds the port code
    always_comb begin
        next_twm_data_in = route_alt[PFS_PIN_TCLK] ?
            I_PAD_IN[PFS_PIN_TCLK] : PFS_TWOWIRE_IDLE;
        next_tws_clock_in = pfs_is_alt1(remote_out_pin_select) ?
            I_PAD_IN[PFS_PIN_REMOTE_OUTPUT] : PFS_TWOWIRE_IDLE;
        // Port code shares the pin with the timer; enables are software's
        next_timer_clock_in =
            (timer_clock_pin_select == PFS_SEL_PORT) ?
            I_PAD_IN[PFS_PIN_TCLK] : 1'b0;
        next_ser0_data_in = route_alt[PFS_PIN_P50] ?
            I_PAD_IN[PFS_PIN_P50] : PFS_SERIAL_IDLE;
        next_ser0_clock_in = route_alt[PFS_PIN_P52] ?
            I_PAD_IN[PFS_PIN_P52] : PFS_SERIAL_IDLE;
        next_ser1_data_in = route_alt[PFS_PIN_P53] ?
            I_PAD_IN[PFS_PIN_P53] : PFS_SERIAL_IDLE;
        next_ser1_clock_in = route_alt[PFS_PIN_P55] ?
            I_PAD_IN[PFS_PIN_P55] : PFS_SERIAL_IDLE;
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_MASTER_TWOWIRE_DATA_IN <= PFS_TWOWIRE_IDLE;
            O_SLAVE_TWOWIRE_CLOCK_IN <= PFS_TWOWIRE_IDLE;
            O_TIMER_EXTERNAL_CLOCK_IN <= 1'b0;
            O_SERIAL_CH0_DATA_IN <= PFS_SERIAL_IDLE;
            O_SERIAL_CH0_CLOCK_IN <= PFS_SERIAL_IDLE;
            O_SERIAL_CH1_DATA_IN <= PFS_SERIAL_IDLE;
            O_SERIAL_CH1_CLOCK_IN <= PFS_SERIAL_IDLE;
        end else begin
            O_MASTER_TWOWIRE_DATA_IN <= next_twm_data_in;
            O_SLAVE_TWOWIRE_CLOCK_IN <= next_tws_clock_in;
            O_TIMER_EXTERNAL_CLOCK_IN <= next_timer_clock_in;
            O_SERIAL_CH0_DATA_IN <= next_ser0_data_in;
            O_SERIAL_CH0_CLOCK_IN <= next_ser0_clock_in;
            O_SERIAL_CH1_DATA_IN <= next_ser1_data_in;
            O_SERIAL_CH1_CLOCK_IN <= next_ser1_clock_in;
        end
    end

endmodule // pfs_top

// >>> testbench/pfs_monitor.sv
// Port-level assertions of the port function select block
`timescale 1ns/1ps
module pfs_monitor
    import pfs_pkg::*;
#(
    parameter bit LARGE_PACKAGE = 1'b1
)
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [PFS_ADDR_WIDTH-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic [PFS_NUM_PINS-1:0] I_PAD_IN,
    input wire logic [PFS_NUM_PINS-1:0] O_PAD_OUT,
    input wire logic [PFS_NUM_PINS-1:0] O_PAD_OE,
    input wire logic [PFS_NUM_PINS-1:0] I_GPIO_OUT,
    input wire logic [PFS_NUM_PINS-1:0] I_GPIO_OE,
    input wire logic [PFS_NUM_PINS-1:0] O_GPIO_IN,
    input wire logic I_REMOTE_OUTPUT,
    input wire logic O_TIMER_EXTERNAL_CLOCK_IN,
    input wire logic O_MASTER_TWOWIRE_DATA_IN,
    input wire logic I_SERIAL_CH0_DATA_OUT,
    input wire logic O_SERIAL_CH0_DATA_IN
);
    localparam logic [17:0] A4 = 18'h14aa4;
    localparam logic [17:0] A5L = 18'h14aa8;
    logic [3:0] sh4;
    logic [7:0] sh5;
    logic [3:0] next_sh4;
    logic [7:0] next_sh5;
    logic wr_ok;
    assign wr_ok = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0];
    // Shadow of the port four and port five low select registers as seen from the bus
    always_comb begin
        next_sh4 = sh4;
        next_sh5 = sh5;
        if (wr_ok && I_AVS_ADDRESS == A4) next_sh4 = I_AVS_WRITEDATA[3:0];
        if (wr_ok && I_AVS_ADDRESS == A5L && LARGE_PACKAGE)
            next_sh5 = I_AVS_WRITEDATA[7:0];
    end
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sh4 <= 4'h0;
            sh5 <= 8'h00;
        end else begin
            sh4 <= next_sh4;
            sh5 <= next_sh5;
        end
    end
    logic [1:0] sel_t;
    logic [1:0] sel_d0;
    logic pad1;
    logic pad2;
    assign sel_t = sh4[3:2];
    assign sel_d0 = sh5[1:0];
    assign pad1 = I_PAD_IN[1];
    assign pad2 = I_PAD_IN[2];

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    sequence s_taken;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
    endsequence
    sequence s_answer;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence
    property p_answer;
        s_taken |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("bad answer");
    property p_wait_cause;
        !O_AVS_WAITREQUEST |-> $past(I_AVS_READ || I_AVS_WRITE);
    endproperty
    a_wait_cause: assert property (p_wait_cause)
        else $error("stray answer");
    property p_rd_p4h;
        !O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS == A4
            |-> O_AVS_READDATA == {28'h0, sh4};
    endproperty
    a_rd_p4h: assert property (p_rd_p4h) else $error("p4 read bad");
    property p_rd_p5l;
        !O_AVS_WAITREQUEST && I_AVS_READ && I_AVS_ADDRESS == A5L
            |-> O_AVS_READDATA == {24'h0, sh5};
    endproperty
    a_rd_p5l: assert property (p_rd_p5l) else $error("p5 read bad");
    // Attempts start only at edges where reset was sampled low
    property p_gpio_in;
        !I_RST |=> O_GPIO_IN == $past(I_PAD_IN);
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("gpio in bad");
    property p_tclk;
        !I_RST |=> O_TIMER_EXTERNAL_CLOCK_IN ==
            (($past(sel_t) == 2'h0) ? $past(pad1) : 1'b0);
    endproperty
    a_tclk: assert property (p_tclk) else $error("timer clock bad");
    property p_master;
        !I_RST |=> O_MASTER_TWOWIRE_DATA_IN ==
            (($past(sel_t) == 2'h1) ? $past(pad1) : 1'b1);
    endproperty
    a_master: assert property (p_master) else $error("master data bad");
    property p_remote;
        !I_RST && sh4[1:0] == 2'h2
            |=> O_PAD_OE[0] && O_PAD_OUT[0] == $past(I_REMOTE_OUTPUT);
    endproperty
    a_remote: assert property (p_remote) else $error("remote pin bad");
    property p_port0;
        !I_RST && sh4[1:0] == 2'h0 |=> {O_PAD_OE[0], O_PAD_OUT[0]} ==
            {$past(I_GPIO_OE[0]), $past(I_GPIO_OUT[0])};
    endproperty
    a_port0: assert property (p_port0) else $error("port pin bad");
    property p_ch0_dout;
        !I_RST && sh5[3:2] == 2'h1
            |=> O_PAD_OE[3] && O_PAD_OUT[3] == $past(I_SERIAL_CH0_DATA_OUT);
    endproperty
    a_ch0_dout: assert property (p_ch0_dout) else $error("ch0 out bad");
    property p_ch0_din;
        !I_RST |=> O_SERIAL_CH0_DATA_IN ==
            (($past(sel_d0) == 2'h1) ? $past(pad2) : 1'b0);
    endproperty
    a_ch0_din: assert property (p_ch0_din) else $error("ch0 in bad");
endmodule // pfs_monitor

bind pfs_top pfs_monitor #(.LARGE_PACKAGE(LARGE_PACKAGE)) u_mon (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_PAD_IN(I_PAD_IN), .O_PAD_OUT(O_PAD_OUT), .O_PAD_OE(O_PAD_OE),
    .I_GPIO_OUT(I_GPIO_OUT), .I_GPIO_OE(I_GPIO_OE), .O_GPIO_IN(O_GPIO_IN),
    .I_REMOTE_OUTPUT(I_REMOTE_OUTPUT),
    .O_TIMER_EXTERNAL_CLOCK_IN(O_TIMER_EXTERNAL_CLOCK_IN),
    .O_MASTER_TWOWIRE_DATA_IN(O_MASTER_TWOWIRE_DATA_IN),
    .I_SERIAL_CH0_DATA_OUT(I_SERIAL_CH0_DATA_OUT),
    .O_SERIAL_CH0_DATA_IN(O_SERIAL_CH0_DATA_IN));

// >>> testbench/pfs_pad_world.sv
// Pad-side model: each pad driven by the block, an outside source or a level that toggles every clock
`timescale 1ns/1ps
module pfs_pad_world
    import pfs_pkg::*;
(
    input wire logic i_clk,
    input wire logic [PFS_NUM_PINS-1:0] i_pad_out,
    input wire logic [PFS_NUM_PINS-1:0] i_pad_oe,
    input wire logic [PFS_NUM_PINS-1:0] i_ext_en,
    input wire logic [PFS_NUM_PINS-1:0] i_ext_val,
    output logic [PFS_NUM_PINS-1:0] o_pad_in
);
    logic [PFS_NUM_PINS-1:0] last;
    always_ff @(posedge i_clk) begin
        last <= o_pad_in;
    end
    // Undriven pads invert their last level at every clock edge
    always_comb begin
        for (int i = 0; i < PFS_NUM_PINS; i++) begin
            if (i_pad_oe[i]) o_pad_in[i] = i_pad_out[i];
            else if (i_ext_en[i]) o_pad_in[i] = i_ext_val[i];
            else o_pad_in[i] = ~last[i];
        end
    end
endmodule // pfs_pad_world

// >>> testbench/pfs_top_bench.sv
// Self-checking bench of the port function select block
`timescale 1ns/1ps
module pfs_top_bench;
    import pfs_pkg::*;
    localparam logic [17:0] ADR [3] = '{18'h14aa4, 18'h14aa8, 18'h14aac};
    logic clk, rst, rd, wr, waitreq;
    logic [17:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic [7:0] pad_in, pad_out, pad_oe, gpio_out, gpio_oe, gpio_in;
    logic [7:0] ext_en, ext_val;
    logic m_out, m_oe, m_in, s_out, s_oe, s_in, remote_output, tclk_in;
    logic c0_di, c0_do, c0_ck, c0_ckoe, c0_cki;
    logic c1_di, c1_do, c1_ck, c1_ckoe, c1_cki;
    logic [7:0] regs [3];
    int error_cnt, compares;

    pfs_top dut (.I_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out),
        .O_PAD_OE(pad_oe), .I_GPIO_OUT(gpio_out), .I_GPIO_OE(gpio_oe),
        .O_GPIO_IN(gpio_in), .I_MASTER_TWOWIRE_DATA_OUT(m_out),
        .I_MASTER_TWOWIRE_DATA_OE(m_oe), .O_MASTER_TWOWIRE_DATA_IN(m_in),
        .I_SLAVE_TWOWIRE_CLOCK_OUT(s_out), .I_SLAVE_TWOWIRE_CLOCK_OE(s_oe),
        .O_SLAVE_TWOWIRE_CLOCK_IN(s_in), .I_REMOTE_OUTPUT(remote_output),
        .O_TIMER_EXTERNAL_CLOCK_IN(tclk_in), .O_SERIAL_CH0_DATA_IN(c0_di),
        .I_SERIAL_CH0_DATA_OUT(c0_do), .I_SERIAL_CH0_CLOCK_OUT(c0_ck),
        .I_SERIAL_CH0_CLOCK_OE(c0_ckoe), .O_SERIAL_CH0_CLOCK_IN(c0_cki),
        .O_SERIAL_CH1_DATA_IN(c1_di), .I_SERIAL_CH1_DATA_OUT(c1_do),
        .I_SERIAL_CH1_CLOCK_OUT(c1_ck), .I_SERIAL_CH1_CLOCK_OE(c1_ckoe),
        .O_SERIAL_CH1_CLOCK_IN(c1_cki));
    pfs_pad_world u_pads (.i_clk(clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad_in(pad_in));

    task automatic conclude();
        $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; the request holds until waitrequest is seen low
    task automatic bus(input logic w, input logic [17:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        // Data bit 8 marks a write with byte lane 0 switched off
        be <= {3'h7, !d[8]};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (w && d[8] === 1'b0)
            for (int i = 0; i < 3; i++)
                if (a == ADR[i]) regs[i] = (i == 1) ? d[7:0] : {4'h0, d[3:0]};
        if (n >= 20) begin
            error_cnt++;
            $display("MISMATCH handshake expected answer seen none");
            conclude();
        end
    endtask

    // Random pin traffic, then pads and peripheral inputs against the model
    task automatic pins();
        logic [1:0] s [8];
        logic [7:0] eo, ee, ep, mk, oe_r;
        s[0] = regs[0][1:0];
        s[1] = regs[0][3:2];
        for (int i = 0; i < 4; i++) s[2+i] = regs[1][2*i+:2];
        s[6] = regs[2][1:0];
        s[7] = regs[2][3:2];
        oe_r = 8'($urandom);
        if (s[1] == 2'h0) oe_r[1] = 1'b0;
        @(posedge clk);
        gpio_oe <= oe_r;
        gpio_out <= 8'($urandom);
        ext_val <= 8'($urandom);
        {m_out, m_oe, s_out, s_oe, remote_output, c0_do, c0_ck, c0_ckoe, c1_do, c1_ck,
            c1_ckoe} <= 11'($urandom);
        repeat (4) @(posedge clk);
        eo = gpio_out;
        ee = gpio_oe;
        mk = 8'hff;
        if (s[0] == 2'h1) {ee[0], eo[0]} = {s_oe, s_out};
        if (s[0] == 2'h2) {ee[0], eo[0]} = {1'b1, remote_output};
        if (s[1] == 2'h1) {ee[1], eo[1]} = {m_oe, m_out};
        if (s[2] == 2'h1) {ee[2], mk[2]} = 2'b00;
        if (s[3] == 2'h1) {ee[3], eo[3]} = {1'b1, c0_do};
        if (s[4] == 2'h1) {ee[4], eo[4]} = {c0_ckoe, c0_ck};
        if (s[5] == 2'h1) {ee[5], mk[5]} = 2'b00;
        if (s[6] == 2'h1) {ee[6], eo[6]} = {1'b1, c1_do};
        if (s[7] == 2'h1) {ee[7], eo[7]} = {c1_ckoe, c1_ck};
        ep = (ee & eo) | (~ee & ext_val);
        chk("pad_oe", {24'h0, ee}, {24'h0, pad_oe});
        chk("pad_out", {24'h0, eo & mk}, {24'h0, pad_out & mk});
        chk("gpio_in", {24'h0, ep}, {24'h0, gpio_in});
        chk("periph_in", {25'h0, s[1] == 2'h1 ? ep[1] : 1'b1,
            s[0] == 2'h1 ? ep[0] : 1'b1, s[1] == 2'h0 ? ep[1] : 1'b0,
            s[2] == 2'h1 ? ep[2] : 1'b0, s[4] == 2'h1 ? ep[4] : 1'b0,
            s[5] == 2'h1 ? ep[5] : 1'b0, s[7] == 2'h1 ? ep[7] : 1'b0},
            {25'h0, m_in, s_in, tclk_in, c0_di, c0_cki, c1_di, c1_cki});
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        logic [31:0] q;
        logic [7:0] v;
        {rst, rd, wr, addr, wdata, be} = {1'b1, 56'h0};
        {gpio_out, gpio_oe, ext_val, ext_en} = 32'h0000_00ff;
        {m_out, m_oe, s_out, s_oe, remote_output, c0_do, c0_ck, c0_ckoe} = 8'h00;
        {c1_do, c1_ck, c1_ckoe} = 3'h0;
        regs = '{default: 8'h00};
        error_cnt = 0;
        compares = 0;
        void'($urandom(5322));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 3; i++) begin
                bus(1'b0, ADR[i], 32'h0, q);
                chk("reset_value", 32'h0, q);
            end
            bus(1'b0, 18'h14ab0, 32'h0, q);
            chk("unmapped_read", 32'h0, q);
            pins();
            $display("reset pass %0d done", k);
            for (int r = 0; r < 3; r++)
                for (int c = 0; c < 4; c++) begin
                    v = {2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3)};
                    bus(1'b1, ADR[r], {23'($urandom), 1'b0, v}, q);
                    bus(1'b0, ADR[r], 32'h0, q);
                    chk("readback", {24'h0, regs[r]}, q);
                    pins();
                end
            $display("field codes done");
            bus(1'b1, ADR[1], 32'h1ff, q);
            bus(1'b1, 18'h14ab0, 32'h0ff, q);
            bus(1'b0, ADR[1], 32'h0, q);
            chk("ignored_write", {24'h0, regs[1]}, q);
            $display("ignored writes done");
            @(posedge clk);
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
            regs = '{default: 8'h00};
        end
        conclude();
    end
endmodule // pfs_top_bench
